// ---- rtl/ddc_consts.vh ----
// ddc_consts.vh: offsets, fields, reset values for the descriptor block
// assumes word addressing on the avalon slave (address in words)
`ifndef DDC_CONSTS_VH
`define DDC_CONSTS_VH
// ---------------------------------------------------------------
// register word offsets
// ---------------------------------------------------------------
`define DDC_OFF_CTRL 3'h0
`define DDC_OFF_SRC 3'h1
`define DDC_OFF_DST 3'h2
`define DDC_OFF_STATUS 3'h3
`define DDC_OFF_IRQ_STAT 3'h4
`define DDC_OFF_IRQ_EN 3'h5
`define DDC_OFF_IRQ_CLR 3'h6
`define DDC_OFF_REMAIN 3'h7
// ---------------------------------------------------------------
// control fields
// ---------------------------------------------------------------
`define DDC_BIT_UNALIGNED_EN 22
`define DDC_BIT_ERROR_EN 21
`define DDC_BIT_DONE_EN 20
`define DDC_BIT_HOLD 19
`define DDC_BIT_ABORT 18
`define DDC_BIT_DIR 17
`define DDC_BIT_ARMED 16
`define DDC_CTRL_RESET 32'h00000000
`define DDC_ADDR_RESET 32'h00000000
// ---------------------------------------------------------------
// status and irq fields
// ---------------------------------------------------------------
`define DDC_ST_FREE 0
`define DDC_ST_FINISHED 1
`define DDC_ST_ERROR 2
`define DDC_IRQ_DONE 0
`define DDC_IRQ_ERROR 1
`define DDC_IRQ_UNALIGNED 2
`define DDC_IRQ_RESET 3'h0
`define DDC_ST_RESET 3'h1
`define DDC_WORD_STEP 32'h00000004
`endif

// ---- rtl/ddc_desc_ctrl.v ----
// ddc_desc_ctrl.v: control of descriptor 0 of a memory dma engine
// assumes one 20 MHz clock, synchronous active-high reset and a
// word-per-cycle data path handshaked by the mover outside
`timescale 1ns/1ps
`include "ddc_consts.vh"

module ddc_desc_ctrl (
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // avalon-mm slave
  input wire [2:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // word mover
  output wire xfer_req,
  output wire xfer_dir,
  output reg [31:0] xfer_src_addr,
  output reg [31:0] xfer_dst_addr,
  input wire xfer_ack,
  input wire xfer_err,
  // status towards arbiter and cpu
  output wire desc_free_flag,
  output wire desc_finished_flag,
  output wire irq
);

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function [31:0] merge_be;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] be;
    integer i;
    begin
      merge_be = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          merge_be[i*8 +: 8] = new_val[i*8 +: 8];
        end
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  reg [31:0] ctrl_reg;
  reg [31:0] src_reg;
  reg [31:0] dst_reg;
  reg [14:0] words_left_reg;
  reg [2:0] status_reg;
  reg [2:0] irq_stat_reg;
  reg [2:0] irq_en_reg;
  reg ack_reg;

  wire armed = ctrl_reg[`DDC_BIT_ARMED];
  wire hold = ctrl_reg[`DDC_BIT_HOLD];
  wire access = (avs_read | avs_write) & ~ack_reg;
  // write lands only on the edge where waitrequest is seen low
  wire wr = avs_write & ack_reg;
  wire [31:0] wmask = merge_be(32'h00000000, avs_writedata,
    avs_byteenable);
  wire [31:0] ctrl_wr = merge_be(ctrl_reg, avs_writedata, avs_byteenable);
  wire wr_ctrl = wr & (avs_address == `DDC_OFF_CTRL);
  wire abort = wr_ctrl & ctrl_wr[`DDC_BIT_ABORT];
  wire arm_now = wr_ctrl & ~armed & ctrl_wr[`DDC_BIT_ARMED] & ~abort;
  wire beat = xfer_req & xfer_ack;
  wire last_beat = beat & (words_left_reg == 15'h0001);
  wire fail = xfer_req & xfer_err;
  wire [15:0] cnt = ctrl_wr[15:0];
  wire odd_size = (cnt[1:0] != 2'h0);
  wire [2:0] irq_clr = (wr & (avs_address == `DDC_OFF_IRQ_CLR)) ?
    wmask[2:0] : 3'h0;
  reg [2:0] irq_set;

  // one wait cycle per access; the answer comes on the second edge
  assign avs_waitrequest = access;

  assign xfer_req = armed & ~hold & (words_left_reg != 15'h0000);
  assign xfer_dir = ctrl_reg[`DDC_BIT_DIR];
  assign desc_free_flag = status_reg[`DDC_ST_FREE];
  assign desc_finished_flag = status_reg[`DDC_ST_FINISHED];
  assign irq = |(irq_stat_reg & irq_en_reg);

  always @* begin
    irq_set = 3'h0;
    if (fail & ctrl_reg[`DDC_BIT_ERROR_EN]) begin
      irq_set[`DDC_IRQ_ERROR] = 1'b1;
    end
    if (last_beat & ~xfer_err & ctrl_reg[`DDC_BIT_DONE_EN]) begin
      irq_set[`DDC_IRQ_DONE] = 1'b1;
    end
    if (arm_now & odd_size & ctrl_wr[`DDC_BIT_UNALIGNED_EN]) begin
      irq_set[`DDC_IRQ_UNALIGNED] = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // registers and transfer progress
  // ---------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_reg <= `DDC_CTRL_RESET;
      src_reg <= `DDC_ADDR_RESET;
      dst_reg <= `DDC_ADDR_RESET;
      words_left_reg <= 15'h0000;
      status_reg <= `DDC_ST_RESET;
      irq_stat_reg <= `DDC_IRQ_RESET;
      irq_en_reg <= 3'h0;
      ack_reg <= 1'b0;
      avs_readdata <= 32'h00000000;
      xfer_src_addr <= 32'h00000000;
      xfer_dst_addr <= 32'h00000000;
    end else begin
      ack_reg <= access;
      if (avs_read & ~ack_reg) begin
        case (avs_address)
          `DDC_OFF_CTRL: avs_readdata <= ctrl_reg;
          `DDC_OFF_SRC: avs_readdata <= src_reg;
          `DDC_OFF_DST: avs_readdata <= dst_reg;
          `DDC_OFF_STATUS: avs_readdata <= {29'h0, status_reg};
          `DDC_OFF_IRQ_STAT: avs_readdata <= {29'h0, irq_stat_reg};
          `DDC_OFF_IRQ_EN: avs_readdata <= {29'h0, irq_en_reg};
          `DDC_OFF_REMAIN: avs_readdata <= {17'h0, words_left_reg};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
      if (wr & (avs_address == `DDC_OFF_IRQ_EN)) begin
        irq_en_reg <= wmask[2:0];
      end
      // set wins over clear
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      if (abort) begin
        ctrl_reg <= `DDC_CTRL_RESET;
        src_reg <= `DDC_ADDR_RESET;
        dst_reg <= `DDC_ADDR_RESET;
        words_left_reg <= 15'h0000;
        status_reg <= `DDC_ST_RESET;
        irq_stat_reg <= `DDC_IRQ_RESET;
      end else begin
        if (wr_ctrl) begin
          if (armed) begin
            ctrl_reg[22:17] <= ctrl_wr[22:17];
          end else begin
            ctrl_reg <= {9'h000, ctrl_wr[22:19], 1'b0, ctrl_wr[17:0]};
          end
        end
        if (arm_now) begin
          words_left_reg <= (cnt[15:2] == 14'h0000) ? 15'h4000 :
            {1'b0, cnt[15:2]};
          status_reg <= 3'h0;
          irq_stat_reg <= irq_set;
          xfer_src_addr <= {src_reg[31:2], 2'h0};
          xfer_dst_addr <= {dst_reg[31:2], 2'h0};
        end
        if (wr & ~armed & (avs_address == `DDC_OFF_SRC)) begin
          src_reg <= merge_be(src_reg, avs_writedata, avs_byteenable) &
            32'hFFFFFFFC;
        end
        if (wr & ~armed & (avs_address == `DDC_OFF_DST)) begin
          dst_reg <= merge_be(dst_reg, avs_writedata, avs_byteenable) &
            32'hFFFFFFFC;
        end
        if (fail) begin
          ctrl_reg[`DDC_BIT_ARMED] <= 1'b0;
          words_left_reg <= 15'h0000;
          status_reg <= 3'h7;
        end else if (beat) begin
          src_reg <= src_reg + `DDC_WORD_STEP;
          dst_reg <= dst_reg + `DDC_WORD_STEP;
          xfer_src_addr <= src_reg + `DDC_WORD_STEP;
          xfer_dst_addr <= dst_reg + `DDC_WORD_STEP;
          words_left_reg <= words_left_reg - 15'h0001;
          if (last_beat) begin
            ctrl_reg[`DDC_BIT_ARMED] <= 1'b0;
            status_reg <= 3'h3;
          end
        end
      end
    end
  end

endmodule

// ---- verif/ddc_mover_model.sv ----
// word mover model: one word per two cycles, or stalls
// assumes one clock shared with the descriptor block
`timescale 1ns/1ps
module ddc_mover_model (
  // control from bench
  input wire sys_clk,
  input wire stall,
  input wire fail,
  // word handshake
  input wire xfer_req,
  output reg xfer_ack = 1'b0,
  output reg xfer_err = 1'b0
);
  always @(posedge sys_clk) begin
    xfer_ack <= xfer_req && !xfer_ack && !stall;
    xfer_err <= xfer_req && fail;
  end
endmodule

// ---- verif/ddc_desc_ctrl_properties.sv ----
// checker: control and word port timing of descriptor 0
// assumes byte enables all high, bound to the block ports
`timescale 1ns/1ps
module ddc_props (
  // bus side
  input wire sys_clk,
  input wire sys_rst,
  input wire [2:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  // word side
  input wire xfer_req,
  input wire xfer_dir,
  input wire [31:0] xfer_src_addr,
  input wire xfer_ack,
  input wire xfer_err,
  input wire desc_free_flag
);
  wire ctl_w = avs_write && !avs_waitrequest && avs_address == 3'h0;
  default clocking @(posedge sys_clk); endclocking
  default disable iff sys_rst;
  sequence arm_s;
    ctl_w && avs_writedata[16] && avs_writedata[19:18] == 2'h0
      && desc_free_flag;
  endsequence
  arm_go_a: assert property (arm_s |=> xfer_req && !desc_free_flag)
    else $error("arm did not start");
  abort_wins_a: assert property (ctl_w && avs_writedata[18]
    |=> !xfer_req && desc_free_flag) else $error("abort lost");
  hold_stop_a: assert property (ctl_w && avs_writedata[19]
    |=> !xfer_req) else $error("hold ignored");
  dir_set_a: assert property (ctl_w && !avs_writedata[18]
    |=> xfer_dir == $past(avs_writedata[17])) else $error("dir");
  addr_step_a: assert property (xfer_req && xfer_ack && !xfer_err
    && !avs_write |=> xfer_src_addr == $past(xfer_src_addr) + 32'h4)
    else $error("step");
  addr_align_a: assert property (xfer_src_addr[1:0] == 2'h0)
    else $error("align");
  err_free_a: assert property (xfer_req && xfer_err && !avs_write
    |=> desc_free_flag && !xfer_req) else $error("err end");
  clr_zero_a: assert property (avs_read && !avs_waitrequest
    && avs_address == 3'h0 |-> !avs_readdata[18]) else $error("bit18");
endmodule
bind ddc_desc_ctrl ddc_props u_props (.sys_clk, .sys_rst, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
  .xfer_req, .xfer_dir, .xfer_src_addr, .xfer_ack, .xfer_err,
  .desc_free_flag);

// ---- verif/tb_ddc_desc_ctrl.sv ----
// bench: register level tests of descriptor 0 control
// assumes the mover model on the word port, byte enables all high
`timescale 1ns/1ps
module tb_ddc_desc_ctrl;
  logic sys_clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0;
  logic avs_write = 1'b0, stall = 1'b0, fail = 1'b0;
  logic [2:0] avs_address = 3'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, xfer_src_addr;
  wire avs_waitrequest, xfer_req, xfer_dir, xfer_ack, xfer_err;
  wire desc_free_flag, irq;
  int num_errors = 0, checks = 0;
  ddc_desc_ctrl dut (.sys_clk, .sys_rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
    .avs_waitrequest, .xfer_req, .xfer_dir, .xfer_src_addr,
    .xfer_dst_addr(), .xfer_ack, .xfer_err, .desc_free_flag,
    .desc_finished_flag(), .irq);
  ddc_mover_model mover (.sys_clk, .stall, .fail, .xfer_req, .xfer_ack,
    .xfer_err);
  initial forever #25 sys_clk = ~sys_clk;
  task end_of_test;
    if (num_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  // request held until waitrequest seen low at an edge
  // waitrequest is sampled mid-cycle, where it has settled
  task req_wait;
    logic w;
    do begin
      @(negedge sys_clk);
      w = avs_waitrequest;
      @(posedge sys_clk);
    end while (w !== 1'b0);
  endtask
  task wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    req_wait;
    avs_write <= 1'b0;
  endtask
  task rc(input logic [2:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    req_wait;
    avs_read <= 1'b0;
    chk($sformatf("reg%0d", a), avs_readdata, e);
  endtask
  task wait_free;
    int n;
    n = 0;
    @(posedge sys_clk);
    while (desc_free_flag !== 1'b1 && n < 500) begin
      @(posedge sys_clk);
      n++;
    end
  endtask
  initial begin
    repeat (3000) @(posedge sys_clk);
    num_errors++;
    end_of_test;
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rc(3'h3, 32'h1);
    wr(3'h5, 32'h7);
    wr(3'h1, 32'h1003);
    rc(3'h1, 32'h1000);
    wr(3'h0, 32'h00110008);
    wait_free;
    rc(3'h3, 32'h3);
    rc(3'h0, 32'h00100008);
    rc(3'h1, 32'h1008);
    chk("irq", irq, 1);
    stall <= 1'b1;
    wr(3'h0, 32'h0041000B);
    rc(3'h4, 32'h4);
    rc(3'h7, 32'h2);
    wr(3'h0, 32'h0049000B);
    wr(3'h1, 32'h5000);
    stall <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("req", xfer_req, 0);
    rc(3'h7, 32'h2);
    wr(3'h0, 32'h0041000B);
    wait_free;
    rc(3'h1, 32'h1010);
    stall <= 1'b1;
    wr(3'h0, 32'h00210000);
    rc(3'h7, 32'h4000);
    stall <= 1'b0;
    fail <= 1'b1;
    wait_free;
    fail <= 1'b0;
    rc(3'h3, 32'h7);
    rc(3'h4, 32'h2);
    stall <= 1'b1;
    wr(3'h0, 32'h00030000);
    @(negedge sys_clk);
    chk("dir", xfer_dir, 1);
    wr(3'h0, 32'h000D0000);
    rc(3'h0, 32'h0);
    rc(3'h3, 32'h1);
    end_of_test;
  end
endmodule
